// ---- include/ccr_consts.vh ----
// constants of the codec control register port
`ifndef CCR_CONSTS_VH
`define CCR_CONSTS_VH

// ----------------------------------------------------------------
// register addresses
// ----------------------------------------------------------------
`define CCR_ADDR_DAC_CONFIG_A 4'h0
`define CCR_ADDR_DAC_CONFIG_B 4'h1
`define CCR_ADDR_DAC_GAIN_CH0 4'h2
`define CCR_ADDR_DAC_GAIN_CH5 4'h7
`define CCR_ADDR_ADC_PEAK_CH0 4'h8
`define CCR_ADDR_ADC_PEAK_CH3 4'hB
`define CCR_ADDR_ADC_CONFIG_A 4'hC
`define CCR_ADDR_ADC_CONFIG_B 4'hD
`define CCR_ADDR_ADC_CONFIG_C 4'hE
`define CCR_ADDR_UNUSED_SLOT 4'hF

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define CCR_RST_CONFIG 10'h000
`define CCR_RST_GAIN 10'h3FF
`define CCR_RST_RESERVED 10'h000

// ----------------------------------------------------------------
// control word layout and field positions
// ----------------------------------------------------------------
`define CCR_WORD_BITS 5'h10
`define CCR_HDR_BITS 5'h05
`define CCR_DATA_START 5'h06
`define CCR_WA_WIDTH_HI 4
`define CCR_WA_WIDTH_LO 3
`define CCR_WA_RATE 1
`define CCR_WA_PD 0
`define CCR_WB_MUTE_HI 5
`define CCR_AA_PD 8
`define CCR_AA_GAIN_HI 2
`define CCR_AB_MUTE_HI 3
`define CCR_AB_FMT_HI 8
`define CCR_AB_FMT_LO 6
`define CCR_AB_MASTER 9
`define CCR_AC_CLK_HI 7
`define CCR_AC_CLK_LO 6

// ----------------------------------------------------------------
// serial output format codes and TDM frame shape
// ----------------------------------------------------------------
`define CCR_FMT_I2S 3'h0
`define CCR_FMT_TDM 3'h6
`define CCR_TDM_SLOTS 8
`define CCR_TDM_SLOT_W 5

`endif

// ---- rtl/ccr_frame.v ----
// extended TDM frame counter for master operation
`timescale 1ns/1ps
`include "ccr_consts.vh"
module ccr_frame #(
	parameter SLOTS = `CCR_TDM_SLOTS,
	parameter SLOT_W = `CCR_TDM_SLOT_W,
	parameter CNT_W = 8
) (
	input wire mclk_in,
	input wire rst_in,
	input wire enable_in,
	input wire bit_rise_in,
	output reg frame_sync_out,
	output reg [CNT_W-SLOT_W-1:0] slot_index_out
);
	localparam integer LAST_I = SLOTS * (1 << SLOT_W) - 1;
	localparam [CNT_W-1:0] LAST = LAST_I[CNT_W-1:0];
	reg [CNT_W-1:0] bit_cnt;

	// ----------------------------------------------------------------
	// bit counter: 8 slots of 32 bits, 256 bit clocks
	// ----------------------------------------------------------------
	always @(posedge mclk_in) begin
		if (rst_in || !enable_in) begin
			bit_cnt <= {CNT_W{1'b0}};
			frame_sync_out <= 1'b0;
			slot_index_out <= {(CNT_W-SLOT_W){1'b0}};
		end else if (bit_rise_in) begin
			if (bit_cnt == LAST) begin
				bit_cnt <= {CNT_W{1'b0}};
			end else begin
				bit_cnt <= bit_cnt + 1'b1;
			end
			// sync marks the first bit clock of each frame
			frame_sync_out <= (bit_cnt == LAST);
			slot_index_out <= (bit_cnt == LAST) ? {(CNT_W-SLOT_W){1'b0}} :
				bit_cnt[CNT_W-1:SLOT_W] + ((bit_cnt[SLOT_W-1:0] == {SLOT_W{1'b1}}) ?
				1'b1 : 1'b0);
		end
	end
endmodule

// ---- rtl/ccr_regbank.v ----
// codec control register bank behind the four-wire serial control port
`timescale 1ns/1ps
`include "ccr_consts.vh"
module ccr_regbank (
	input wire mclk_in,
	input wire rst_in,
	input wire control_serial_clock_in,
	input wire control_word_select_n_in,
	input wire control_serial_in,
	output reg control_serial_out_out,
	output wire control_serial_out_oe_out,
	input wire audio_bit_clock_in,
	input wire [9:0] adc_peak_ch0_in,
	input wire [9:0] adc_peak_ch1_in,
	input wire [9:0] adc_peak_ch2_in,
	input wire [9:0] adc_peak_ch3_in,
	output wire [2:0] serial_output_format_out,
	output wire tdm_master_out,
	output wire tdm_active_out,
	output wire [1:0] word_width_out,
	output wire rate_96k_out,
	output wire [1:0] clock_mode_out,
	output wire [2:0] adc_gain_out,
	output wire [5:0] dac_mute_out,
	output wire [3:0] adc_mute_out,
	output wire dac_powerdown_out,
	output wire adc_powerdown_out,
	output wire [9:0] dac_gain_ch0_out,
	output wire [9:0] dac_gain_ch1_out,
	output wire [9:0] dac_gain_ch2_out,
	output wire [9:0] dac_gain_ch3_out,
	output wire [9:0] dac_gain_ch4_out,
	output wire [9:0] dac_gain_ch5_out,
	output wire frame_sync_out,
	output wire [2:0] slot_index_out
);
	// ----------------------------------------------------------------
	// states of the control word receiver
	// ----------------------------------------------------------------
	localparam [2:0] ST_IDLE = 3'b001;
	localparam [2:0] ST_SHIFT = 3'b010;
	localparam [2:0] ST_LATCH = 3'b100;

	reg [2:0] state;
	reg [2:0] next_state;

	// ----------------------------------------------------------------
	// register storage
	// ----------------------------------------------------------------
	reg [9:0] dac_config_a;
	reg [9:0] dac_config_b;
	reg [9:0] dac_gain_ch0;
	reg [9:0] dac_gain_ch1;
	reg [9:0] dac_gain_ch2;
	reg [9:0] dac_gain_ch3;
	reg [9:0] dac_gain_ch4;
	reg [9:0] dac_gain_ch5;
	reg [9:0] adc_config_a;
	reg [9:0] adc_config_b;
	reg [9:0] adc_config_c;

	// ----------------------------------------------------------------
	// pin synchronisation and edge detection
	// ----------------------------------------------------------------
	wire [3:0] pins_sync;
	wire sclk_s;
	wire sel_n_s;
	wire sdi_s;
	wire bclk_s;
	reg sclk_d;
	reg sel_n_d;
	reg bclk_d;

	ccr_sync #(
		.WIDTH(4)
	) u_sync (
		.mclk_in(mclk_in),
		.rst_in(rst_in),
		// bit order: control clock in bit 0, select in 1, data in 2, bit clock in 3
		.async_in({
			audio_bit_clock_in,
			control_serial_in,
			control_word_select_n_in,
			control_serial_clock_in
		}),
		.sync_out(pins_sync)
	);

	assign sclk_s = pins_sync[0];
	assign sel_n_s = pins_sync[1];
	assign sdi_s = pins_sync[2];
	assign bclk_s = pins_sync[3];

	// delayed copies reset to the cleared synchroniser value, not the pin's idle
	// level: a mismatch would fake a select fall right after reset
	always @(posedge mclk_in) begin
		if (rst_in) begin
			sclk_d <= 1'b0;
			sel_n_d <= 1'b0;
			bclk_d <= 1'b0;
		end else begin
			sclk_d <= sclk_s;
			sel_n_d <= sel_n_s;
			bclk_d <= bclk_s;
		end
	end

	// ----------------------------------------------------------------
	// edge detectors on the synchronised pins
	// ----------------------------------------------------------------
	wire sclk_rise = sclk_s & ~sclk_d;
	wire sclk_fall = ~sclk_s & sclk_d;
	wire sel_fall = ~sel_n_s & sel_n_d;
	wire sel_rise = sel_n_s & ~sel_n_d;
	wire bclk_rise = bclk_s & ~bclk_d;

	// ----------------------------------------------------------------
	// control word shifter
	// ----------------------------------------------------------------
	reg [15:0] shift_in;
	reg [4:0] bit_cnt;
	reg overrun;
	reg rd_active;
	reg [9:0] out_shift;

	wire [3:0] word_addr = shift_in[15:12];
	wire word_is_read = shift_in[11];
	wire [9:0] word_data = shift_in[9:0];
	// bit 10 is never looked at, so a word with it set still writes its data
	wire commit = (state == ST_LATCH) && sclk_rise;
	// peak and reserved slots have no storage, so their writes end here
	wire addr_is_peak = (word_addr >= `CCR_ADDR_ADC_PEAK_CH0) &&
		(word_addr <= `CCR_ADDR_ADC_PEAK_CH3);
	wire addr_is_reserved = (word_addr == `CCR_ADDR_UNUSED_SLOT);
	wire addr_writable = !addr_is_peak && !addr_is_reserved;
	wire do_write = commit && !word_is_read && addr_writable;

	// ----------------------------------------------------------------
	// read data select
	// ----------------------------------------------------------------
	function [9:0] read_word;
		input [3:0] a;
		begin
			case (a)
				`CCR_ADDR_DAC_CONFIG_A: read_word = dac_config_a;
				`CCR_ADDR_DAC_CONFIG_B: read_word = dac_config_b;
				4'h2: read_word = dac_gain_ch0;
				4'h3: read_word = dac_gain_ch1;
				4'h4: read_word = dac_gain_ch2;
				4'h5: read_word = dac_gain_ch3;
				4'h6: read_word = dac_gain_ch4;
				`CCR_ADDR_DAC_GAIN_CH5: read_word = dac_gain_ch5;
				`CCR_ADDR_ADC_PEAK_CH0: read_word = adc_peak_ch0_in;
				4'h9: read_word = adc_peak_ch1_in;
				4'hA: read_word = adc_peak_ch2_in;
				`CCR_ADDR_ADC_PEAK_CH3: read_word = adc_peak_ch3_in;
				`CCR_ADDR_ADC_CONFIG_A: read_word = adc_config_a;
				`CCR_ADDR_ADC_CONFIG_B: read_word = adc_config_b;
				`CCR_ADDR_ADC_CONFIG_C: read_word = adc_config_c;
				default: read_word = `CCR_RST_RESERVED;
			endcase
		end
	endfunction

	// ----------------------------------------------------------------
	// receiver next-state logic
	// ----------------------------------------------------------------
	// the clock alone never starts a word; only select does
	always @* begin
		next_state = state;
		case (state)
			ST_IDLE: begin
				if (sel_fall) begin
					next_state = ST_SHIFT;
				end
			end
			ST_SHIFT: begin
				if (sel_rise) begin
					// short or long words are dropped, never latched
					if (bit_cnt == `CCR_WORD_BITS && !overrun) begin
						next_state = ST_LATCH;
					end else begin
						next_state = ST_IDLE;
					end
				end
			end
			ST_LATCH: begin
				// a new word before the extra clock loses the old word
				if (sel_fall) begin
					next_state = ST_SHIFT;
				end else if (sclk_rise) begin
					next_state = ST_IDLE;
				end
			end
			default: next_state = ST_IDLE;
		endcase
	end

	// ----------------------------------------------------------------
	// receiver state and input shifter
	// ----------------------------------------------------------------
	always @(posedge mclk_in) begin
		if (rst_in) begin
			state <= ST_IDLE;
		end else begin
			state <= next_state;
		end
	end

	always @(posedge mclk_in) begin
		if (rst_in) begin
			shift_in <= 16'h0000;
			bit_cnt <= 5'h00;
			overrun <= 1'b0;
		end else if (state != ST_SHIFT && next_state == ST_SHIFT) begin
			bit_cnt <= 5'h00;
			overrun <= 1'b0;
		end else if (state == ST_SHIFT && sclk_rise && !sel_n_s) begin
			shift_in <= {shift_in[14:0], sdi_s};
			if (bit_cnt == `CCR_WORD_BITS) begin
				overrun <= 1'b1;
			end else begin
				bit_cnt <= bit_cnt + 5'h01;
			end
		end
	end

	// ----------------------------------------------------------------
	// read data out, ten bits in the data field of the same word
	// ----------------------------------------------------------------
	always @(posedge mclk_in) begin
		if (rst_in) begin
			rd_active <= 1'b0;
			out_shift <= 10'h000;
			control_serial_out_out <= 1'b0;
		end else if (state != ST_SHIFT) begin
			rd_active <= 1'b0;
			control_serial_out_out <= 1'b0;
		end else if (sclk_fall) begin
			// five bits in: the address and the read flag are complete
			if (bit_cnt == `CCR_HDR_BITS && shift_in[0]) begin
				rd_active <= 1'b1;
				out_shift <= read_word(shift_in[4:1]);
			end else if (rd_active && bit_cnt >= `CCR_DATA_START &&
				bit_cnt < `CCR_WORD_BITS) begin
				control_serial_out_out <= out_shift[9];
				out_shift <= {out_shift[8:0], 1'b0};
			end
		end
	end

	// ----------------------------------------------------------------
	// serial output enable, only while the read word is still framed
	// ----------------------------------------------------------------
	assign control_serial_out_oe_out = rd_active && (state == ST_SHIFT);

	// ----------------------------------------------------------------
	// power-down fallback to I2S
	// ----------------------------------------------------------------
	// setting either power-down bit drops the audio port back to I2S, so
	// the host must program TDM again after every power-down
	wire pd_dac = (word_addr == `CCR_ADDR_DAC_CONFIG_A) && word_data[`CCR_WA_PD];
	wire pd_adc = (word_addr == `CCR_ADDR_ADC_CONFIG_A) && word_data[`CCR_AA_PD];
	wire pd_request = do_write && (pd_dac || pd_adc);

	// ----------------------------------------------------------------
	// register writes
	// ----------------------------------------------------------------

	always @(posedge mclk_in) begin
		if (rst_in) begin
			dac_config_a <= `CCR_RST_CONFIG;
			dac_config_b <= `CCR_RST_CONFIG;
			dac_gain_ch0 <= `CCR_RST_GAIN;
			dac_gain_ch1 <= `CCR_RST_GAIN;
			dac_gain_ch2 <= `CCR_RST_GAIN;
			dac_gain_ch3 <= `CCR_RST_GAIN;
			dac_gain_ch4 <= `CCR_RST_GAIN;
			dac_gain_ch5 <= `CCR_RST_GAIN;
			adc_config_a <= `CCR_RST_CONFIG;
			adc_config_b <= `CCR_RST_CONFIG;
			adc_config_c <= `CCR_RST_CONFIG;
		end else if (do_write) begin
			case (word_addr)
				`CCR_ADDR_DAC_CONFIG_A: dac_config_a <= word_data;
				`CCR_ADDR_DAC_CONFIG_B: dac_config_b <= word_data;
				4'h2: dac_gain_ch0 <= word_data;
				4'h3: dac_gain_ch1 <= word_data;
				4'h4: dac_gain_ch2 <= word_data;
				4'h5: dac_gain_ch3 <= word_data;
				4'h6: dac_gain_ch4 <= word_data;
				`CCR_ADDR_DAC_GAIN_CH5: dac_gain_ch5 <= word_data;
				`CCR_ADDR_ADC_CONFIG_A: adc_config_a <= word_data;
				`CCR_ADDR_ADC_CONFIG_B: adc_config_b <= word_data;
				`CCR_ADDR_ADC_CONFIG_C: adc_config_c <= word_data;
				default: dac_config_a <= dac_config_a;
			endcase
			if (pd_request) begin
				adc_config_b[`CCR_AB_FMT_HI:`CCR_AB_FMT_LO] <= `CCR_FMT_I2S;
			end
		end
	end

	// ----------------------------------------------------------------
	// decoded controls
	// ----------------------------------------------------------------
	assign serial_output_format_out = adc_config_b[`CCR_AB_FMT_HI:`CCR_AB_FMT_LO];
	assign tdm_master_out = adc_config_b[`CCR_AB_MASTER];
	assign tdm_active_out = (serial_output_format_out == `CCR_FMT_TDM);
	assign word_width_out = dac_config_a[`CCR_WA_WIDTH_HI:`CCR_WA_WIDTH_LO];
	// the 96 kHz request is held off while TDM framing is chosen
	assign rate_96k_out = dac_config_a[`CCR_WA_RATE] && !tdm_active_out;
	assign clock_mode_out = adc_config_c[`CCR_AC_CLK_HI:`CCR_AC_CLK_LO];
	assign adc_gain_out = adc_config_a[`CCR_AA_GAIN_HI:0];
	assign dac_mute_out = dac_config_b[`CCR_WB_MUTE_HI:0];
	assign adc_mute_out = adc_config_b[`CCR_AB_MUTE_HI:0];
	assign dac_powerdown_out = dac_config_a[`CCR_WA_PD];
	assign adc_powerdown_out = adc_config_a[`CCR_AA_PD];

	// ----------------------------------------------------------------
	// volume outputs
	// ----------------------------------------------------------------
	assign dac_gain_ch0_out = dac_gain_ch0;
	assign dac_gain_ch1_out = dac_gain_ch1;
	assign dac_gain_ch2_out = dac_gain_ch2;
	assign dac_gain_ch3_out = dac_gain_ch3;
	assign dac_gain_ch4_out = dac_gain_ch4;
	assign dac_gain_ch5_out = dac_gain_ch5;

	// ----------------------------------------------------------------
	// TDM frame generation as master
	// ----------------------------------------------------------------
	// a powered-down ADC also stops the frame counter
	wire frame_enable = tdm_active_out && tdm_master_out && !adc_powerdown_out;

	ccr_frame #(
		.SLOTS(`CCR_TDM_SLOTS),
		.SLOT_W(`CCR_TDM_SLOT_W),
		.CNT_W(8)
	) u_frame (
		.mclk_in(mclk_in),
		.rst_in(rst_in),
		.enable_in(frame_enable),
		.bit_rise_in(bclk_rise),
		.frame_sync_out(frame_sync_out),
		.slot_index_out(slot_index_out)
	);
endmodule

// ---- rtl/ccr_sync.v ----
// two-flop synchroniser bank for pin inputs
`timescale 1ns/1ps
module ccr_sync #(
	parameter WIDTH = 4
) (
	input wire mclk_in,
	input wire rst_in,
	input wire [WIDTH-1:0] async_in,
	output wire [WIDTH-1:0] sync_out
);
	genvar i;
	generate
		for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
			reg meta;
			reg stable;
			// the first stage feeds the second stage only
			always @(posedge mclk_in) begin
				if (rst_in) begin
					meta <= 1'b0;
					stable <= 1'b0;
				end else begin
					meta <= async_in[i];
					stable <= meta;
				end
			end
			assign sync_out[i] = stable;
		end
	endgenerate
endmodule

// ---- tb/ccr_host_model.sv ----
// host model that masters the four-wire control port
`timescale 1ns/1ps
module ccr_host_model (
	input wire sdo_in,
	input wire sdo_oe_in,
	output logic sclk_out,
	output logic sel_n_out,
	output logic sdi_out
);
	logic last;
	// a released line shows the inverse of its last bit, never a stale copy
	wire line = sdo_oe_in ? sdo_in : ~last;

	always @(sdo_in, sdo_oe_in)
		if (sdo_oe_in)
			last = sdo_in;

	// ----------------------------------------
	// free-running control clock, 800 ns
	// ----------------------------------------
	initial begin
		last = 1'b0;
		sel_n_out = 1'b1;
		sdi_out = 1'b0;
		sclk_out = 1'b0;
		// edges land on falling edges of the master clock
		#100;
		forever #400 sclk_out = ~sclk_out;
	end

	// data changes on falling edges, read bits are taken just before the next change
	task xfer(input logic [15:0] w, input integer nb, output logic [9:0] rd);
		integer i;
		begin
			rd = 10'h000;
			@(negedge sclk_out);
			sel_n_out = 1'b0;
			sdi_out = w[15];
			for (i = 15; i > 15 - nb; i = i - 1) begin
				@(negedge sclk_out);
				if (i < 10)
					rd[i] = line;
				if (i > 16 - nb)
					sdi_out = w[i - 1];
				else begin
					sel_n_out = 1'b1;
					sdi_out = ~w[i];
				end
			end
			repeat (3) @(posedge sclk_out);
		end
	endtask
endmodule

// ---- tb/ccr_regbank_checker.sv ----
// concurrent checks on the pins of the codec control register port
`timescale 1ns/1ps
module ccr_regbank_checker (
	input logic mclk_in,
	input logic rst_in,
	input logic control_word_select_n_in,
	input logic control_serial_out_oe_out,
	input logic audio_bit_clock_in,
	input logic [2:0] serial_output_format_out,
	input logic tdm_master_out,
	input logic tdm_active_out,
	input logic rate_96k_out,
	input logic [9:0] dac_gain_ch0_out,
	input logic frame_sync_out,
	input logic [2:0] slot_index_out
);
	logic [4:0] idle_cnt;
	logic [2:0] bclk_q;
	logic [8:0] rise_cnt;
	logic fs_q;
	logic seen;
	wire on = tdm_active_out && tdm_master_out;
	wire rise = bclk_q[1] && !bclk_q[2];

	// ----------------------------------------
	// helper counters
	// ----------------------------------------
	// same two-flop delay as the design, so the frame count lines up
	always @(posedge mclk_in) begin
		bclk_q <= {bclk_q[1:0], audio_bit_clock_in};
		fs_q <= frame_sync_out;
		if (rst_in || !control_word_select_n_in)
			idle_cnt <= 5'h00;
		else if (idle_cnt != 5'h1F)
			idle_cnt <= idle_cnt + 5'h01;
		if (rst_in || (frame_sync_out && !fs_q))
			rise_cnt <= {8'h00, rise};
		else
			rise_cnt <= rise_cnt + {8'h00, rise};
		if (rst_in || !on)
			seen <= 1'b0;
		else if (frame_sync_out && !fs_q)
			seen <= 1'b1;
	end

	// ----------------------------------------
	// properties
	// ----------------------------------------
	default clocking cb @(posedge mclk_in);
	endclocking
	default disable iff (rst_in);

	a_fmt_decode: assert property (tdm_active_out == (serial_output_format_out == 3'h6))
		else $error("tdm flag disagrees with format");
	a_rate_tdm: assert property (tdm_active_out |-> !rate_96k_out)
		else $error("fast rate while tdm");
	a_oe_select: assert property (control_word_select_n_in [*8] |-> !control_serial_out_oe_out)
		else $error("serial out driven without select");
	a_idle_stable: assert property (idle_cnt == 5'h1F |->
		$stable({serial_output_format_out, tdm_master_out, dac_gain_ch0_out}))
		else $error("register moved without a framed word");
	a_reset_vals: assert property ($fell(rst_in) |-> dac_gain_ch0_out == 10'h3FF &&
		serial_output_format_out == 3'h0 && !control_serial_out_oe_out && !frame_sync_out)
		else $error("bad state after reset");
	a_frame_gate: assert property ((!on) [*2] |-> !frame_sync_out)
		else $error("frame sync outside tdm master");
	a_frame_len: assert property ($rose(frame_sync_out) && seen |-> rise_cnt == 9'h100)
		else $error("frame length not 256 bit clocks");
	a_slot_step: assert property (on && $past(on) && $changed(slot_index_out) |->
		slot_index_out == $past(slot_index_out) + 3'h1)
		else $error("slot index skipped");

	c_frame: cover property ($rose(frame_sync_out) && seen);
	c_read: cover property ($rose(control_serial_out_oe_out));
	c_tdm: cover property ($rose(tdm_active_out));
endmodule

bind ccr_regbank ccr_regbank_checker u_chk (.mclk_in(mclk_in), .rst_in(rst_in),
	.control_word_select_n_in(control_word_select_n_in),
	.control_serial_out_oe_out(control_serial_out_oe_out),
	.audio_bit_clock_in(audio_bit_clock_in), .serial_output_format_out(serial_output_format_out),
	.tdm_master_out(tdm_master_out), .tdm_active_out(tdm_active_out),
	.rate_96k_out(rate_96k_out), .dac_gain_ch0_out(dac_gain_ch0_out),
	.frame_sync_out(frame_sync_out), .slot_index_out(slot_index_out));

// ---- tb/ccr_regbank_tb.sv ----
// self-checking bench for the codec control register port
`timescale 1ns/1ps
module ccr_regbank_tb;
	logic mclk_in, rst_in, bclk;
	logic [9:0] peak [0:3];
	logic [9:0] mdl [0:15];
	logic [9:0] rd;
	wire sclk, sel_n, sdi, sdo, sdo_oe, tdm_m, tdm_a, r96, dpd, apd, fsync;
	wire [2:0] fmt, ag, slot;
	wire [1:0] ww, cm;
	wire [5:0] dm;
	wire [3:0] am;
	wire [9:0] g0, g1, g2, g3, g4, g5;
	integer n_fail, checks, bcnt, a, n0;

	ccr_regbank u_dut (.mclk_in(mclk_in), .rst_in(rst_in), .control_serial_clock_in(sclk),
		.control_word_select_n_in(sel_n), .control_serial_in(sdi),
		.control_serial_out_out(sdo), .control_serial_out_oe_out(sdo_oe),
		.audio_bit_clock_in(bclk), .adc_peak_ch0_in(peak[0]), .adc_peak_ch1_in(peak[1]),
		.adc_peak_ch2_in(peak[2]), .adc_peak_ch3_in(peak[3]), .serial_output_format_out(fmt),
		.tdm_master_out(tdm_m), .tdm_active_out(tdm_a), .word_width_out(ww),
		.rate_96k_out(r96), .clock_mode_out(cm), .adc_gain_out(ag), .dac_mute_out(dm),
		.adc_mute_out(am), .dac_powerdown_out(dpd), .adc_powerdown_out(apd),
		.dac_gain_ch0_out(g0), .dac_gain_ch1_out(g1), .dac_gain_ch2_out(g2),
		.dac_gain_ch3_out(g3), .dac_gain_ch4_out(g4), .dac_gain_ch5_out(g5),
		.frame_sync_out(fsync), .slot_index_out(slot));
	ccr_host_model u_host (.sdo_in(sdo), .sdo_oe_in(sdo_oe), .sclk_out(sclk),
		.sel_n_out(sel_n), .sdi_out(sdi));

	// ----------------------------------------
	// clocks
	// ----------------------------------------
	initial begin
		mclk_in = 1'b0;
		forever #50 mclk_in = ~mclk_in;
	end
	initial begin
		bclk = 1'b0;
		bcnt = 0;
		#200;
		forever #400 bclk = ~bclk;
	end
	always @(posedge bclk)
		bcnt = bcnt + 1;

	// ----------------------------------------
	// tasks
	// ----------------------------------------
	task final_report;
		begin
			if (n_fail == 0 && checks > 0)
				$display("Regression OK");
			else
				$display("Regression broken");
			$finish;
		end
	endtask
	task cmp(input logic [63:0] got, input logic [63:0] exp);
		begin
			checks = checks + 1;
			if (got !== exp) begin
				n_fail = n_fail + 1;
				$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
			end
		end
	endtask
	task do_reset;
		begin
			@(negedge mclk_in);
			rst_in = 1'b1;
			repeat (3) @(negedge mclk_in);
			rst_in = 1'b0;
			for (a = 0; a < 16; a = a + 1)
				mdl[a] = (a > 1 && a < 8) ? 10'h3FF : 10'h000;
			repeat (3) @(negedge mclk_in);
		end
	endtask
	task wr(input logic [3:0] wa, input logic [9:0] d);
		begin
			u_host.xfer({wa, 2'b00, d}, 16, rd);
			if (wa < 4'h8 || (wa > 4'hB && wa != 4'hF))
				mdl[wa] = d;
			if ((wa == 4'hC && d[8]) || (wa == 4'h0 && d[0]))
				mdl[13][8:6] = 3'h0;
			repeat (8) @(negedge mclk_in);
		end
	endtask
	task readall;
		begin
			for (a = 0; a < 16; a = a + 1) begin
				u_host.xfer({a[3:0], 2'b10, 10'h000}, 16, rd);
				cmp({54'h0, rd}, {54'h0, (a > 7 && a < 12) ? peak[a - 8] : mdl[a]});
			end
		end
	endtask
	task ports_chk;
		logic [2:0] f;
		begin
			f = mdl[13][8:6];
			cmp({g0, g1, g2, g3, g4, g5}, {mdl[2], mdl[3], mdl[4], mdl[5], mdl[6], mdl[7]});
			cmp({fmt, tdm_m, tdm_a, ww, r96, cm, ag, dm, am, dpd, apd}, {f, mdl[13][9],
				f == 3'h6, mdl[0][4:3], mdl[0][1] & (f != 3'h6), mdl[14][7:6], mdl[12][2:0],
				mdl[1][5:0], mdl[13][3:0], mdl[0][0], mdl[12][8]});
		end
	endtask
	task wait_fs;
		integer k;
		logic p;
		begin
			k = 0;
			p = 1'b1;
			while (!(p === 1'b0 && fsync === 1'b1)) begin
				p = fsync;
				@(negedge mclk_in);
				k = k + 1;
				if (k > 3000) begin
					cmp(64'h0, 64'h1);
					final_report;
				end
			end
		end
	endtask

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		n_fail = 0;
		checks = 0;
		rst_in = 1'b1;
		peak[0] = 10'h15A;
		peak[1] = 10'h2C3;
		peak[2] = 10'h3FE;
		peak[3] = 10'h001;
		do_reset;
		readall;
		ports_chk;
		for (a = 0; a < 16; a = a + 1)
			wr(a[3:0], {a[3:0], ~a[3:0], a[1:0]});
		readall;
		ports_chk;
		for (a = 0; a < 4; a = a + 1) begin
			wr(4'h0, {5'h00, a[1:0], 1'b0, a[0], 1'b0});
			ports_chk;
		end
		wr(4'hE, 10'h040);
		ports_chk;
		wr(4'hE, 10'h000);
		ports_chk;
		u_host.xfer({4'hE, 2'b00, 10'h0C0}, 15, rd);
		repeat (8) @(negedge mclk_in);
		ports_chk;
		wr(4'hC, 10'h000);
		wr(4'hC, 10'h000);
		wr(4'h1, 10'h000);
		wr(4'h1, 10'h000);
		wr(4'hD, 10'h380);
		ports_chk;
		wait_fs;
		n0 = bcnt;
		wait_fs;
		cmp(64'(bcnt - n0), 64'h100);
		peak[0] = 10'h2A7;
		peak[3] = 10'h380;
		readall;
		wr(4'hC, 10'h100);
		ports_chk;
		do_reset;
		readall;
		ports_chk;
		final_report;
	end
endmodule
